// File: hdl/hspi_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides, parameterised width and depth.
  Assumes both sides run on clk; depth is a power of two.
*/
`timescale 1ns/10ps
`default_nettype none

module hspi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic s_valid,
  input wire logic [WIDTH-1:0] s_data,
  output logic s_ready,
  output logic m_valid,
  output logic [WIDTH-1:0] m_data,
  input wire logic m_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } hspi_fifo_state_t;

  hspi_fifo_state_t f_q, f_d;
  logic push, pop;

  // Full and empty are flops so s_ready and m_valid come straight from state
  always_comb begin
    f_d = f_q;
    push = s_valid & ~f_q.full;
    pop = m_ready & ~f_q.empty;
    if (push) begin
      f_d.mem[f_q.wp] = s_data;
      f_d.wp = AW'(f_q.wp + 1'b1);
    end
    if (pop) begin
      f_d.rp = AW'(f_q.rp + 1'b1);
    end
    case ({push, pop})
      2'b10: f_d.cnt = (AW+1)'(f_q.cnt + 1'b1);
      2'b01: f_d.cnt = (AW+1)'(f_q.cnt - 1'b1);
      default: f_d.cnt = f_q.cnt;
    endcase
    f_d.full = (f_d.cnt == (AW+1)'(DEPTH));
    f_d.empty = (f_d.cnt == '0);
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      f_q <= '0;
      f_q.empty <= 1'b1;
    end else begin
      f_q <= f_d;
    end
  end

  assign s_ready = ~f_q.full;
  assign m_valid = ~f_q.empty;
  assign m_data = f_q.mem[f_q.rp];

endmodule // hspi_fifo

`default_nettype wire

// File: hdl/hspi_port.sv
/*
  Host serial port: SPI slave with header decode, burst register and FIFO
  access, clear-on-read event flags with enables, and interrupt routing to GPIOs.
  Assumes the host drives chip select and serial clock well below clk/4; all
  link pins are asynchronous and pass two flops. Event, state and stream ports
  come from logic on clk.
*/
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Sample on rising, change on falling SCLK
// - MISO released while chip select high
// - Bytes shifted most significant bit first
// - Header bit 7: address or command
// - Header bit 0: read when set
// - Return two machine state bytes first
// - Burst access, address increments per byte
// - Address 0xff reaches the data FIFOs
// - Port works in every power state
// - Interrupt output routed to chosen GPIO
// - Flag bits 0-11 are packet events
// - Flags 12-14: preamble, sync, carrier sense
// - Flags 15-21 status, 29 timeout, 30 cipher
// - Wake-up flag waits for crystal oscillator
// - Ready flag needs settled crystal oscillator
// - Status bytes clear when read
// - Status bit high after its event
// - Mask bit zero blocks that interrupt
// - GPIO code zero gives active-low request
module hspi_port
  import hspi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  output logic [GPIO_NUM-1:0] gpio_out,
  input wire logic [31:0] event_pulse,
  input wire logic crystal_oscillator_ready,
  input wire logic [15:0] machine_state_bytes,
  output logic [7:0] cmd_code,
  output logic cmd_strobe,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready
);

  typedef struct packed {
    logic [2:0] sync1; // {chip_select_n, sclk, mosi}
    logic [2:0] sync2;
    logic sclk_prev;
    hspi_phase_t phase;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] tx_next;
    logic is_read;
    logic is_cmd;
    logic [7:0] addr;
    logic [31:0] flags;
    logic [31:0] enables;
    logic [GPIO_NUM-1:0][4:0] gpio_conf;
    logic wake_pend;
    logic irq_n;
    logic [GPIO_NUM-1:0] gpio;
    logic miso;
    logic miso_oe_n;
    logic [7:0] cmd_code;
    logic cmd_strobe;
  } hspi_regs_t;

  hspi_regs_t r_q, r_d;

  // Word lane decode, shared by read, write and clear paths
  function automatic logic lane_hit(input logic [7:0] a, input logic [7:0] base);
    return a[7:2] == base[7:2];
  endfunction

  function automatic logic [7:0] reg_read(input logic [7:0] a, input hspi_regs_t r,
                                          input logic [15:0] ms);
    logic [4:0] sh;
    sh = {a[1:0], 3'h0};
    if (lane_hit(a, ADDR_GPIO_CONF)) begin
      return {3'h0, r.gpio_conf[a[1:0]]};
    end else if (a[7:1] == ADDR_STATE[7:1]) begin
      return a[0] ? ms[7:0] : ms[15:8];
    end else if (lane_hit(a, ADDR_ENABLES)) begin
      return r.enables[sh +: 8];
    end else if (lane_hit(a, ADDR_FLAGS)) begin
      return r.flags[sh +: 8];
    end else begin
      return 8'h00;
    end
  endfunction

  logic cs_act, rise, fall, byte_done, mosi_s;
  logic [7:0] byte_in, acc_addr;
  logic do_fetch, do_write;
  logic [31:0] set_vec, clr_vec;
  logic tx_push, tx_s_ready, tx_err;
  logic rx_pop, rx_m_valid, rx_err;
  logic [7:0] rx_m_data;

  // Host writes toward the core; back-pressure shows as overflow flag
  hspi_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk(clk),
    .reset(reset),
    .s_valid(tx_push),
    .s_data(byte_in),
    .s_ready(tx_s_ready),
    .m_valid(tx_valid),
    .m_data(tx_data),
    .m_ready(tx_ready)
  );

  // Core receive stream toward host reads
  hspi_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(clk),
    .reset(reset),
    .s_valid(rx_valid),
    .s_data(rx_data),
    .s_ready(rx_ready),
    .m_valid(rx_m_valid),
    .m_data(rx_m_data),
    .m_ready(rx_pop)
  );

  // Next-state logic for the whole port
  always_comb begin
    r_d = r_q;
    r_d.cmd_strobe = 1'b0;
    // Link pins: only the second stage feeds any logic
    r_d.sync1 = {chip_select_n, sclk, mosi};
    r_d.sync2 = r_q.sync1;
    r_d.sclk_prev = r_q.sync2[1];
    cs_act = ~r_q.sync2[2];
    mosi_s = r_q.sync2[0];
    rise = cs_act & r_q.sync2[1] & ~r_q.sclk_prev;
    fall = cs_act & ~r_q.sync2[1] & r_q.sclk_prev;
    byte_in = {r_q.rx_shift[6:0], mosi_s};
    byte_done = rise & (r_q.bit_cnt == 3'h7);
    acc_addr = (r_q.phase == HSPI_ADDR) ? byte_in : r_q.addr;
    do_fetch = 1'b0;
    do_write = 1'b0;
    tx_push = 1'b0;
    tx_err = 1'b0;
    rx_pop = 1'b0;
    rx_err = 1'b0;
    clr_vec = 32'h0000_0000;

    // No power-state gating: the port runs on clk in every state
    if (!cs_act) begin
      r_d.phase = HSPI_IDLE;
      r_d.bit_cnt = 3'h0;
      r_d.tx_shift = machine_state_bytes[15:8];
      r_d.tx_next = machine_state_bytes[7:0];
    end else begin
      if (r_q.phase == HSPI_IDLE) begin
        r_d.phase = HSPI_HEAD;
      end
      if (rise) begin
        r_d.rx_shift = byte_in;
        r_d.bit_cnt = 3'(r_q.bit_cnt + 1'b1);
      end
      if (byte_done) begin
        case (r_q.phase)
          HSPI_HEAD: begin
            r_d.is_cmd = byte_in[HDR_AC_BIT];
            r_d.is_read = byte_in[HDR_RW_BIT];
            r_d.phase = HSPI_ADDR;
          end
          HSPI_ADDR: begin
            r_d.phase = HSPI_DATA;
            if (r_q.is_cmd) begin
              r_d.cmd_code = byte_in;
              r_d.cmd_strobe = 1'b1;
            end else begin
              r_d.addr = byte_in;
              do_fetch = r_q.is_read;
            end
          end
          HSPI_DATA: begin
            // Bytes after a command are ignored
            do_fetch = ~r_q.is_cmd & r_q.is_read;
            do_write = ~r_q.is_cmd & ~r_q.is_read;
          end
          default: begin
            r_d.phase = HSPI_HEAD;
          end
        endcase
      end
      // Next byte is loaded one falling edge after the eighth rising edge
      if (fall) begin
        r_d.tx_shift = (r_q.bit_cnt == 3'h0) ? r_q.tx_next : {r_q.tx_shift[6:0], 1'b0};
      end
    end

    // Read prefetch: the byte is fetched, popped or cleared before it is shifted out
    if (do_fetch) begin
      if (acc_addr == ADDR_FIFO) begin
        rx_pop = rx_m_valid;
        rx_err = ~rx_m_valid;
        r_d.tx_next = rx_m_valid ? rx_m_data : 8'h00;
      end else begin
        r_d.tx_next = reg_read(acc_addr, r_q, machine_state_bytes);
        if (lane_hit(acc_addr, ADDR_FLAGS)) begin
          clr_vec[{acc_addr[1:0], 3'h0} +: 8] = 8'hff;
        end
      end
    end
    if (do_write) begin
      r_d.tx_next = 8'h00;
      if (acc_addr == ADDR_FIFO) begin
        tx_push = tx_s_ready;
        tx_err = ~tx_s_ready;
      end else if (lane_hit(acc_addr, ADDR_ENABLES)) begin
        r_d.enables[{acc_addr[1:0], 3'h0} +: 8] = byte_in;
      end else if (lane_hit(acc_addr, ADDR_GPIO_CONF)) begin
        r_d.gpio_conf[acc_addr[1:0]] = byte_in[4:0];
      end
    end
    // FIFO address stays put so a burst keeps streaming bytes
    if ((do_fetch || do_write) && acc_addr != ADDR_FIFO) begin
      r_d.addr = 8'(acc_addr + 1'b1);
    end

    // Event flags: unused positions never set
    set_vec = event_pulse & FLAG_USED;
    set_vec[FLAG_TX_FIFO_ERR] = event_pulse[FLAG_TX_FIFO_ERR] | tx_err;
    set_vec[FLAG_RX_FIFO_ERR] = event_pulse[FLAG_RX_FIFO_ERR] | rx_err;
    // Wake-up event is held until the oscillator clock is there
    set_vec[FLAG_WAKE_TIMEOUT] = (r_q.wake_pend | event_pulse[FLAG_WAKE_TIMEOUT])
                                 & crystal_oscillator_ready;
    r_d.wake_pend = (r_q.wake_pend | event_pulse[FLAG_WAKE_TIMEOUT])
                    & ~crystal_oscillator_ready;
    set_vec[FLAG_READY] = event_pulse[FLAG_READY] & crystal_oscillator_ready;
    // Set wins over a clear by read in the same cycle
    r_d.flags = (r_q.flags & ~clr_vec) | set_vec;

    // Request low while any enabled flag stands
    r_d.irq_n = ~|(r_q.flags & r_q.enables);
    for (int i = 0; i < GPIO_NUM; i++) begin
      if (r_q.gpio_conf[i] == GPIO_SEL_IRQ) begin
        r_d.gpio[i] = r_q.irq_n;
      end else if (r_q.gpio_conf[i] == GPIO_SEL_LOW) begin
        r_d.gpio[i] = 1'b0;
      end else begin
        r_d.gpio[i] = 1'b1; // Other selections idle high here
      end
    end

    // Pin drive, registered so outputs come from flops
    r_d.miso = r_d.tx_shift[7];
    r_d.miso_oe_n = r_q.sync2[2];
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      r_q <= '0;
      r_q.sync1 <= 3'h4;
      r_q.sync2 <= 3'h4;
      r_q.phase <= HSPI_IDLE;
      r_q.flags <= FLAGS_RST;
      r_q.enables <= ENABLES_RST;
      r_q.gpio_conf <= {GPIO_NUM{GPIO_CONF_RST}};
      r_q.irq_n <= 1'b1;
      r_q.gpio <= {GPIO_NUM{1'b1}};
      r_q.miso_oe_n <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign miso = r_q.miso;
  assign miso_oe_n = r_q.miso_oe_n;
  assign gpio_out = r_q.gpio;
  assign cmd_code = r_q.cmd_code;
  assign cmd_strobe = r_q.cmd_strobe;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_miso_release: assert property (
    r_q.sync2[2] |=> miso_oe_n)
    else $error("MISO driven while chip select high");

  chk_msb_first: assert property (
    (fall && r_q.bit_cnt != 3'h0) |=> r_q.tx_shift[7] == $past(r_q.tx_shift[6]))
    else $error("Outgoing byte not shifted MSB first");

  chk_state_bytes: assert property (
    (!cs_act && !$past(cs_act) && !$past(reset)) |-> r_q.tx_shift == $past(machine_state_bytes[15:8]))
    else $error("State byte not loaded ahead of access");

  chk_burst_incr: assert property (
    (do_write && acc_addr != ADDR_FIFO && r_q.phase == HSPI_DATA)
      |=> r_q.addr == $past(r_q.addr) + 8'h01)
    else $error("Burst address did not increment");

  chk_fifo_push: assert property (
    (do_write && acc_addr == ADDR_FIFO && tx_s_ready) |=> tx_valid && r_q.addr == $past(r_q.addr))
    else $error("FIFO write did not reach transmit FIFO");

  chk_read_clear: assert property (
    (do_fetch && acc_addr == ADDR_FLAGS && set_vec[7:0] == 8'h00) |=> r_q.flags[7:0] == 8'h00)
    else $error("Status byte not cleared by read");

  chk_mask_block: assert property (
    ((r_q.flags & r_q.enables) == 32'h0 && r_q.gpio_conf[0] == GPIO_SEL_IRQ)
      ##1 (r_q.gpio_conf[0] == GPIO_SEL_IRQ) |=> gpio_out[0])
    else $error("Masked flags raised the request");

  chk_irq_gpio: assert property (
    ((r_q.flags & r_q.enables) != 32'h0 && r_q.gpio_conf[0] == GPIO_SEL_IRQ) [*2]
      |=> !gpio_out[0])
    else $error("Enabled flag did not pull request low");

  chk_wake_xo: assert property (
    $rose(r_q.flags[FLAG_WAKE_TIMEOUT]) |-> $past(crystal_oscillator_ready))
    else $error("Wake-up flag set without oscillator");

  chk_ready_xo: assert property (
    $rose(r_q.flags[FLAG_READY]) |-> $past(crystal_oscillator_ready))
    else $error("Ready flag set without settled oscillator");

  cov_command: cover property (r_q.cmd_strobe);
  cov_fifo_read: cover property (rx_pop);
  cov_irq_low: cover property (!gpio_out[0]);

endmodule // hspi_port

`default_nettype wire

// File: inc/hspi_pkg.sv
/*
  Constants and types shared by the host serial port block and its FIFO.
  Assumes a single 25 MHz system clock with a synchronous active-high reset.
*/
`default_nettype none

package hspi_pkg;

  // Register byte addresses on the serial port
  localparam logic [7:0] ADDR_GPIO_CONF = 8'h40; // Four bytes, one per GPIO pin
  localparam logic [7:0] ADDR_STATE = 8'h54; // Two machine state bytes, read only
  localparam logic [7:0] ADDR_ENABLES = 8'h58; // Four bytes, bits 7:0 at lowest address
  localparam logic [7:0] ADDR_FLAGS = 8'h5c; // Four bytes, clear on read
  localparam logic [7:0] ADDR_FIFO = 8'hff; // Data FIFOs

  // Header byte fields
  localparam int HDR_AC_BIT = 7;
  localparam int HDR_RW_BIT = 0;

  // Reset values
  localparam logic [31:0] ENABLES_RST = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [4:0] GPIO_CONF_RST = 5'h00;

  // Implemented event flags: bits 0..21, 29 and 30
  localparam logic [31:0] FLAG_USED = 32'h603f_ffff;
  localparam int FLAG_TX_FIFO_ERR = 5;
  localparam int FLAG_RX_FIFO_ERR = 6;
  localparam int FLAG_WAKE_TIMEOUT = 15;
  localparam int FLAG_READY = 16;

  // GPIO output selection codes
  localparam logic [4:0] GPIO_SEL_IRQ = 5'h00;
  localparam logic [4:0] GPIO_SEL_HIGH = 5'h13;
  localparam logic [4:0] GPIO_SEL_LOW = 5'h14;
  localparam int GPIO_NUM = 4;

  // Data FIFO shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // Serial transfer phase, Gray coded along idle, header, address, data
  typedef enum logic [1:0] {
    HSPI_IDLE = 2'b00,
    HSPI_HEAD = 2'b01,
    HSPI_ADDR = 2'b11,
    HSPI_DATA = 2'b10
  } hspi_phase_t;

endpackage

`default_nettype wire

// File: test/hspi_host.sv
/*
  Host model: the serial master that talks to the port, 320 ns per bit.
  Assumes a 40 ns clk; the caller fills tx_b and reads rx_b around xfer.
*/
`timescale 1ns/10ps
`default_nettype none

module hspi_host (
  input wire logic clk,
  output logic sclk,
  output logic chip_select_n,
  output logic mosi,
  input wire logic miso_pin
);
  logic [7:0] tx_b [16];
  logic [7:0] rx_b [16];

  // Link idles deselected with the clock low
  initial begin
    sclk = 1'h0;
    chip_select_n = 1'h1;
    mosi = 1'h0;
  end

  // Whole bytes only; the host alone moves select and clock
  task automatic xfer(input int n);
    @(posedge clk);
    chip_select_n <= 1'h0;
    mosi <= tx_b[0][7];
    repeat (50) @(posedge clk); // At least 2 us before first rise
    for (int i = 0; i < 8 * n; i++) begin
      sclk <= 1'h1;
      repeat (3) @(posedge clk);
      #1 rx_b[i/8][7-i%8] = miso_pin;
      @(posedge clk);
      sclk <= 1'h0;
      if (i < 8 * n - 1) begin
        mosi <= tx_b[(i+1)/8][7-(i+1)%8];
      end
      repeat (4) @(posedge clk);
    end
    chip_select_n <= 1'h1;
    mosi <= ~mosi; // Released line must not look like held data
    repeat (8) @(posedge clk);
    #1;
  endtask
endmodule // hspi_host

`default_nettype wire

// File: test/hspi_port_tb.sv
/*
  Bench for the host serial port: one task per scenario, via the host model.
  Assumes hspi_pkg and hspi_host are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); \
  end \
end

module hspi_port_tb;
  import hspi_pkg::*;
  logic clk = 1'h0;
  logic reset = 1'h1;
  wire logic sclk, chip_select_n, mosi, miso_pin;
  logic miso, miso_oe_n, cmd_strobe, tx_valid, rx_ready;
  logic [3:0] gpio_out;
  logic [7:0] cmd_code, tx_data;
  logic [31:0] event_pulse = 32'h0;
  logic xo_rdy = 1'h1;
  logic [15:0] ms_bytes = 16'h8c31;
  logic tx_ready = 1'h0;
  logic rx_valid = 1'h0;
  logic [7:0] rx_data = 8'h0;
  logic [5:0] cs_h = 6'h3f;
  logic [31:0] v;
  int err_count = 0;
  int n_compared = 0;
  int n_strobe = 0;

  // Pin level seen by the host; floats when not driven
  assign miso_pin = miso_oe_n ? 1'hz : miso;

  hspi_port i_dut (
    .clk(clk), .reset(reset), .sclk(sclk), .chip_select_n(chip_select_n),
    .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n), .gpio_out(gpio_out),
    .event_pulse(event_pulse), .crystal_oscillator_ready(xo_rdy),
    .machine_state_bytes(ms_bytes), .cmd_code(cmd_code), .cmd_strobe(cmd_strobe),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready)
  );

  hspi_host i_host (
    .clk(clk), .sclk(sclk), .chip_select_n(chip_select_n), .mosi(mosi),
    .miso_pin(miso_pin)
  );

  // 25 MHz clock
  always #20 clk = ~clk;

  // Output enable follows select once it has settled for a while
  always @(posedge clk) begin
    cs_h <= {cs_h[4:0], chip_select_n};
    if (!reset && cs_h == 6'h3f) `CHK(miso_oe_n, 1'h1)
    if (cs_h == 6'h00) `CHK(miso_oe_n, 1'h0)
    if (cmd_strobe === 1'h1) begin
      n_strobe++;
    end
  end

  // Header, address or command, then n data bytes from tx_b[2..]
  task automatic acc(input logic [7:0] h, input logic [7:0] a, input int n);
    i_host.tx_b[0] = h; // Other header bits zero
    i_host.tx_b[1] = a;
    i_host.xfer(n + 2);
    `CHK(i_host.rx_b[0], ms_bytes[15:8])
    `CHK(i_host.rx_b[1], ms_bytes[7:0])
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    for (int k = 0; k < 4; k++) i_host.tx_b[2+k] = d[8*k +: 8];
    acc(8'h00, a, 4);
  endtask

  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    for (int k = 0; k < 4; k++) i_host.tx_b[2+k] = 8'h00;
    acc(8'h01, a, 4);
    for (int k = 0; k < 4; k++) d[8*k +: 8] = i_host.rx_b[2+k];
  endtask

  // One-cycle event, then time for flag and request to settle
  task automatic pulse(input logic [31:0] p);
    @(posedge clk) event_pulse <= p;
    @(posedge clk) event_pulse <= 32'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    `CHK(gpio_out, 4'hf)
    `CHK({tx_valid, rx_ready, cmd_strobe}, 3'h2)
    rd32(ADDR_ENABLES, v);
    `CHK(v, ENABLES_RST)
    rd32(ADDR_FLAGS, v);
    `CHK(v, FLAGS_RST)
  endtask

  task automatic t_regs;
    wr32(ADDR_ENABLES, 32'h1234_8001);
    rd32(ADDR_ENABLES, v);
    `CHK(v, 32'h1234_8001)
    wr32(ADDR_STATE, 32'hffff_ffff);
    rd32(ADDR_STATE, v); // Runs past the state bytes into empty space
    `CHK(v, {16'h0, ms_bytes[7:0], ms_bytes[15:8]})
  endtask

  task automatic t_irq;
    wr32(ADDR_GPIO_CONF, 32'h0013_1400);
    `CHK(gpio_out, 4'hd)
    pulse(32'h2);
    `CHK(gpio_out, 4'hd)
    pulse(32'h1);
    `CHK(gpio_out, 4'h4)
    rd32(ADDR_FLAGS, v);
    `CHK(v, 32'h3)
    `CHK(gpio_out, 4'hd)
    rd32(ADDR_FLAGS, v);
    `CHK(v, 32'h0)
  endtask

  task automatic t_flags;
    pulse(32'hffff_ffff);
    rd32(ADDR_FLAGS, v);
    `CHK(v, 32'h603f_ffff)
    @(posedge clk) xo_rdy <= 1'h0;
    pulse(32'h0001_8000);
    rd32(ADDR_FLAGS, v);
    `CHK(v, 32'h0)
    @(posedge clk) xo_rdy <= 1'h1;
    repeat (4) @(posedge clk);
    rd32(ADDR_FLAGS, v);
    `CHK(v, 32'h8000)
  endtask

  task automatic t_cmd;
    acc(8'h80, 8'h63, 0);
    `CHK(n_strobe, 1)
    `CHK(cmd_code, 8'h63)
  endtask

  // Overrun the transmit FIFO while the core side stalls, fill the receive FIFO, then read past its end
  task automatic t_fifo;
    for (int k = 0; k < 9; k++) i_host.tx_b[2+k] = 8'h10 + 8'(k);
    acc(8'h00, ADDR_FIFO, 9);
    rd32(ADDR_FLAGS, v);
    `CHK(v, 32'h20)
    for (int k = 0; k < 8; k++) begin
      `CHK({tx_valid, tx_data}, {1'h1, 8'h10 + 8'(k)})
      @(posedge clk) tx_ready <= 1'h1;
      @(posedge clk) tx_ready <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
    end
    `CHK(tx_valid, 1'h0)
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) begin
        rx_valid <= 1'h1;
        rx_data <= 8'ha0 + 8'(k);
      end
      @(posedge clk) rx_valid <= 1'h0;
      @(posedge clk);
    end
    #1 `CHK(rx_ready, 1'h0)
    for (int k = 0; k < 9; k++) i_host.tx_b[2+k] = 8'h00;
    acc(8'h01, ADDR_FIFO, 9);
    for (int k = 0; k < 9; k++) `CHK(i_host.rx_b[2+k], k < 8 ? 8'ha0 + 8'(k) : 8'h00)
    rd32(ADDR_FLAGS, v);
    `CHK(v, 32'h40)
    `CHK(rx_ready, 1'h1)
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_regs();
    t_irq();
    t_flags();
    t_cmd();
    t_fifo();
    end_sim();
  end

  // Watchdog, about five times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule // hspi_port_tb

`default_nettype wire
